//--- design/up_down_capture_reload_timer.sv
// Purpose: 16-bit capture / auto-reload / toggle timer, one instance
// Assumes: Register port is on core_clk; pins are asynchronous
// Notes: Instantiate three times for the three timers
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
// Overview of operation
// - 16-bit count, bytes read/written separately
// - Clock: system_clock, /2, /12, ext/8, pin
// - Counter select picks pin falling edges
// - Clock field 00=/12 01=sys 10=ext/8 11=/2
// - Decrement enable: trigger high up, low down
// - Decrement enable blocks trigger capture/reload
// - Capture mode trigger fall copies count
// - Capture sets external flag
// - Capture mode up overflow sets flag
// - Capture mode down wrap sets flag
// - Capture mode needs select and run
// - External enable clear ignores trigger
// - Reload up overflow loads reload value
// - Reload mode trigger fall reloads count
// - Reload down match loads 0xffff
// - Select clear is reload; run starts
// - Reload mode external flag toggles
// - Toggle output inverts on overflow
// - Toggle bit reads/forces output
// - Square wave period from reload value
// - Overflow pulses for ADC and DAC
module up_down_capture_reload_timer (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic countInputPin,
	input wire logic extTriggerPin,
	input wire logic extClockPin,
	output logic toggleOut,
	output logic toggleOutEnable,
	output logic overflowPulse,
	output logic timerIrq
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] timerControlReg;
	logic [7:0] timerConfigReg;
	logic [15:0] count;
	logic [15:0] reload;
	logic [3:0] div12Count;
	logic div2Phase;
	logic [2:0] ext8Count;
	logic countLevel;
	logic countFall;
	logic trigLevel;
	logic trigFall;
	logic extLevel;
	logic extFall;
	logic running;
	logic captureMode;
	logic countDown;
	logic tick;
	logic trigAct;
	logic wrapEvent;
	logic [15:0] next_count;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// One write decode, shared by every register
	function automatic logic writeHit(input logic we, input logic [2:0] addr,
		input logic [2:0] target);
		return we & (addr == target);
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	edge_sync countSync (
		.core_clk(core_clk),
		.rst(rst),
		.pinIn(countInputPin),
		.level(countLevel),
		.fall(countFall)
	);
	edge_sync trigSync (
		.core_clk(core_clk),
		.rst(rst),
		.pinIn(extTriggerPin),
		.level(trigLevel),
		.fall(trigFall)
	);
	edge_sync extSync (
		.core_clk(core_clk),
		.rst(rst),
		.pinIn(extClockPin),
		.level(extLevel),
		.fall(extFall)
	);

	// ------------------------------------------------------------
	// Prescalers
	// ------------------------------------------------------------
	// Free running so the first tick phase is independent of run
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div12Count <= 4'h0;
			div2Phase <= 1'b0;
		end else begin
			div12Count <= (div12Count == timer_pkg::DIV12_LAST) ? 4'h0 : div12Count + 4'h1;
			div2Phase <= ~div2Phase;
		end
	end

	// External clock counted on its falling edges
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ext8Count <= 3'h0;
		end else if (extFall) begin
			ext8Count <= ext8Count + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	assign running = timerControlReg[timer_pkg::CTL_RUN];
	assign captureMode = timerControlReg[timer_pkg::CTL_CAPTURE_SELECT];
	// Synchronised level only: the raw pin may change mid-cycle
	assign countDown = timerConfigReg[timer_pkg::CFG_DECREMENT] & ~trigLevel;

	always_comb begin
		if (timerControlReg[timer_pkg::CTL_COUNTER_SELECT]) begin
			tick = countFall;
		end else begin
			case (timerConfigReg[timer_pkg::CFG_CLKSEL_MSB:timer_pkg::CFG_CLKSEL_LSB])
				timer_pkg::CLK_DIV12: tick = (div12Count == timer_pkg::DIV12_LAST);
				timer_pkg::CLK_SYS: tick = 1'b1;
				timer_pkg::CLK_EXT8: tick = extFall & (ext8Count == timer_pkg::EXT8_LAST);
				timer_pkg::CLK_DIV2: tick = div2Phase;
				default: tick = 1'b0;
			endcase
		end
	end

	// Trigger edge acts only with external enable, no decrement, run
	assign trigAct = running & trigFall & timerControlReg[timer_pkg::CTL_EXT_ENABLE]
		& ~timerConfigReg[timer_pkg::CFG_DECREMENT];

	// Overflow or underflow on this tick
	always_comb begin
		wrapEvent = 1'b0;
		next_count = count;
		if (running & tick) begin
			if (countDown) begin
				if (captureMode) begin
					wrapEvent = (count == timer_pkg::COUNT_RESET);
					next_count = count - 16'h0001;
				end else if (count == reload) begin
					wrapEvent = 1'b1;
					next_count = timer_pkg::COUNT_MAX;
				end else begin
					next_count = count - 16'h0001;
				end
			end else begin
				wrapEvent = (count == timer_pkg::COUNT_MAX);
				if (wrapEvent & ~captureMode) begin
					next_count = reload;
				end else begin
					next_count = count + 16'h0001;
				end
			end
		end
		if (trigAct & ~captureMode) begin
			next_count = reload;
		end
	end

	// ------------------------------------------------------------
	// Count and reload/capture registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= timer_pkg::COUNT_RESET;
		end else if (writeHit(regWrite, regAddr, timer_pkg::ADDR_COUNT_LOW)) begin
			count[7:0] <= regWrData;
		end else if (writeHit(regWrite, regAddr, timer_pkg::ADDR_COUNT_HIGH)) begin
			count[15:8] <= regWrData;
		end else begin
			count <= next_count;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reload <= timer_pkg::COUNT_RESET;
		end else if (trigAct & captureMode) begin
			reload <= count;
		end else if (writeHit(regWrite, regAddr, timer_pkg::ADDR_RELOAD_LOW)) begin
			reload[7:0] <= regWrData;
		end else if (writeHit(regWrite, regAddr, timer_pkg::ADDR_RELOAD_HIGH)) begin
			reload[15:8] <= regWrData;
		end
	end

	// ------------------------------------------------------------
	// Control register and flags
	// ------------------------------------------------------------
	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timerControlReg <= timer_pkg::CONTROL_RESET;
		end else begin
			if (writeHit(regWrite, regAddr, timer_pkg::ADDR_CONTROL)) begin
				timerControlReg <= regWrData & 8'hcf;
			end
			if (wrapEvent) begin
				timerControlReg[timer_pkg::CTL_OVF_FLAG] <= 1'b1;
			end
			if (trigAct) begin
				timerControlReg[timer_pkg::CTL_EXT_FLAG] <= 1'b1;
			end else if (wrapEvent & ~captureMode) begin
				timerControlReg[timer_pkg::CTL_EXT_FLAG] <=
					~timerControlReg[timer_pkg::CTL_EXT_FLAG];
			end
		end
	end

	// Toggle state lives in the config register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timerConfigReg <= timer_pkg::CONFIG_RESET;
		end else if (writeHit(regWrite, regAddr, timer_pkg::ADDR_CONFIG)) begin
			timerConfigReg <= regWrData & 8'h1f;
		end else if (wrapEvent & timerConfigReg[timer_pkg::CFG_OUT_ENABLE]) begin
			timerConfigReg[timer_pkg::CFG_TOGGLE] <= ~timerConfigReg[timer_pkg::CFG_TOGGLE];
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// One-cycle pulse, registered, for ADC start and DAC update
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			overflowPulse <= 1'b0;
		end else begin
			overflowPulse <= wrapEvent;
		end
	end

	assign toggleOut = timerConfigReg[timer_pkg::CFG_TOGGLE];
	assign toggleOutEnable = timerConfigReg[timer_pkg::CFG_OUT_ENABLE];
	// In reload mode the external flag is a count bit, not a request
	assign timerIrq = timerControlReg[timer_pkg::CTL_OVF_FLAG]
		| (timerControlReg[timer_pkg::CTL_EXT_FLAG] & captureMode);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				timer_pkg::ADDR_CONTROL: regRdData <= timerControlReg;
				timer_pkg::ADDR_CONFIG: regRdData <= timerConfigReg;
				timer_pkg::ADDR_RELOAD_LOW: regRdData <= reload[7:0];
				timer_pkg::ADDR_RELOAD_HIGH: regRdData <= reload[15:8];
				timer_pkg::ADDR_COUNT_LOW: regRdData <= count[7:0];
				timer_pkg::ADDR_COUNT_HIGH: regRdData <= count[15:8];
				default: regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	holdStopped_a: assert property (@(posedge core_clk) disable iff (rst)
		(!running && !regWrite) |=> $stable(count))
		else $error("count moved while stopped");
	upReload_a: assert property (@(posedge core_clk) disable iff (rst)
		(wrapEvent && !captureMode && !countDown && !regWrite) |=> (count == $past(reload)))
		else $error("no reload on overflow");
	downReload_a: assert property (@(posedge core_clk) disable iff (rst)
		(wrapEvent && !captureMode && countDown && !regWrite && !trigAct)
		|=> (count == 16'hffff))
		else $error("no 0xffff on underflow");
	captureCopy_a: assert property (@(posedge core_clk) disable iff (rst)
		(trigAct && captureMode) |=> (reload == $past(count)))
		else $error("capture missed");
	extFlagSet_a: assert property (@(posedge core_clk) disable iff (rst)
		trigAct |=> timerControlReg[6])
		else $error("external flag not set");
	ovfFlagSet_a: assert property (@(posedge core_clk) disable iff (rst)
		wrapEvent |=> (timerControlReg[7] && overflowPulse))
		else $error("overflow flag not set");
	decBlocks_a: assert property (@(posedge core_clk) disable iff (rst)
		timerConfigReg[0] |-> !trigAct)
		else $error("trigger acted with decrement");
	toggleFlip_a: assert property (@(posedge core_clk) disable iff (rst)
		(wrapEvent && timerConfigReg[1] && !regWrite) |=> (toggleOut != $past(toggleOut)))
		else $error("toggle missed");
	// Count and config writes override hardware updates, so seven checks exclude them
	captureStep_a: assert property (@(posedge core_clk) disable iff (rst)
		(running && tick && captureMode && !regWrite)
		|=> (count == ($past(countDown) ? $past(count) - 16'h0001 : $past(count) + 16'h0001)))
		else $error("capture mode step wrong");
	trigReload_a: assert property (@(posedge core_clk) disable iff (rst)
		(trigAct && !captureMode && !regWrite) |=> (count == $past(reload)))
		else $error("no reload on trigger");
	extToggle_a: assert property (@(posedge core_clk) disable iff (rst)
		(wrapEvent && !captureMode && !trigAct && !regWrite)
		|=> (timerControlReg[6] != $past(timerControlReg[6])))
		else $error("external flag did not toggle");
	ovfKept_a: assert property (@(posedge core_clk) disable iff (rst)
		(timerControlReg[7] && !writeHit(regWrite, regAddr, timer_pkg::ADDR_CONTROL))
		|=> timerControlReg[7])
		else $error("overflow flag cleared by hardware");
	extKept_a: assert property (@(posedge core_clk) disable iff (rst)
		(timerControlReg[6] && captureMode
		&& !writeHit(regWrite, regAddr, timer_pkg::ADDR_CONTROL)) |=> timerControlReg[6])
		else $error("external flag cleared by hardware");
	stoppedQuiet_a: assert property (@(posedge core_clk) disable iff (rst)
		!running |-> (!wrapEvent && !trigAct))
		else $error("event while stopped");
	irqCapture_a: assert property (@(posedge core_clk) disable iff (rst)
		(captureMode && (timerControlReg[6] || timerControlReg[7])) |-> timerIrq)
		else $error("capture mode request missing");
	irqReload_a: assert property (@(posedge core_clk) disable iff (rst)
		(!captureMode && !timerControlReg[7]) |-> !timerIrq)
		else $error("reload mode flag raised a request");
	readBack_a: assert property (@(posedge core_clk) disable iff (rst)
		(regRead && (regAddr == timer_pkg::ADDR_COUNT_LOW))
		|=> (regRdData == $past(count[7:0])))
		else $error("count low byte read wrong");
	pulseCause_a: assert property (@(posedge core_clk) disable iff (rst)
		overflowPulse |-> $past(wrapEvent))
		else $error("pulse without wrap");
	upOnly_a: assert property (@(posedge core_clk) disable iff (rst)
		!timerConfigReg[timer_pkg::CFG_DECREMENT] |-> !countDown)
		else $error("counted down without decrement enable");
endmodule // up_down_capture_reload_timer
`default_nettype wire

//--- inc/timer_pkg.sv
// Purpose: Constants for the up/down capture/reload timer
// Assumes: 8-bit register port, 100 MHz core clock
// Notes: Offsets index byte registers on the plain port
`default_nettype none
package timer_pkg;
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_CONFIG = 3'h1;
	localparam logic [2:0] ADDR_RELOAD_LOW = 3'h2;
	localparam logic [2:0] ADDR_RELOAD_HIGH = 3'h3;
	localparam logic [2:0] ADDR_COUNT_LOW = 3'h4;
	localparam logic [2:0] ADDR_COUNT_HIGH = 3'h5;
	// Control register fields
	localparam int CTL_CAPTURE_SELECT = 0;
	localparam int CTL_COUNTER_SELECT = 1;
	localparam int CTL_RUN = 2;
	localparam int CTL_EXT_ENABLE = 3;
	localparam int CTL_EXT_FLAG = 6;
	localparam int CTL_OVF_FLAG = 7;
	// Config register fields
	localparam int CFG_DECREMENT = 0;
	localparam int CFG_OUT_ENABLE = 1;
	localparam int CFG_TOGGLE = 2;
	localparam int CFG_CLKSEL_LSB = 3;
	localparam int CFG_CLKSEL_MSB = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [1:0] CLK_DIV12 = 2'h0;
	localparam logic [1:0] CLK_SYS = 2'h1;
	localparam logic [1:0] CLK_EXT8 = 2'h2;
	localparam logic [1:0] CLK_DIV2 = 2'h3;
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [2:0] EXT8_LAST = 3'h7;
endpackage
`default_nettype wire

//--- design/edge_sync.sv
// Purpose: Two-flop synchroniser with falling-edge detect
// Assumes: Input asynchronous to core_clk
// Notes: Edge logic reads only the second and third flops
`default_nettype none
module edge_sync (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pinIn,
	output logic level,
	output logic fall
);
	logic meta;
	logic sync;
	logic prev;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= pinIn;
			sync <= meta;
			prev <= sync;
		end
	end
	assign level = sync;
	assign fall = prev & ~sync;
endmodule // edge_sync
`default_nettype wire

//--- testbench/pin_model.sv
// Purpose: Far-side pins: count input, trigger, external clock
// Assumes: Pins idle high; pulses slow enough for the synchroniser
// Notes: External clock stands high while extRun is low
`default_nettype none
module pin_model (
	input wire logic core_clk,
	input wire logic extRun,
	output logic countPin,
	output logic trigPin,
	output logic extClk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		countPin = 1'b1;
		trigPin = 1'b1;
		extClk = 1'b1;
	end
	// 12.5 MHz, well under a quarter of the core rate
	always #40 extClk = extRun ? ~extClk : 1'b1;
	// Four cycles low and high, so each level outlives the synchroniser
	task automatic fallCount(input int n);
		repeat (n) begin
			@(posedge core_clk);
			countPin <= 1'b0;
			repeat (4) @(posedge core_clk);
			countPin <= 1'b1;
			repeat (4) @(posedge core_clk);
		end
	endtask
	task automatic setTrig(input logic lvl);
		@(posedge core_clk);
		trigPin <= lvl;
		repeat (6) @(posedge core_clk);
	endtask
endmodule // pin_model
`default_nettype wire

//--- testbench/up_down_capture_reload_timer_bench.sv
// Purpose: Self-checking bench for one timer instance
// Assumes: Register map and field positions from timer_pkg
// Notes: Counter-select mode gives exact counts from pin pulses
`default_nettype none
module up_down_capture_reload_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] CTL = timer_pkg::ADDR_CONTROL;
	localparam logic [2:0] CFG = timer_pkg::ADDR_CONFIG;
	localparam logic [2:0] RLD = timer_pkg::ADDR_RELOAD_LOW;
	localparam logic [2:0] CNT = timer_pkg::ADDR_COUNT_LOW;
	logic core_clk, rst, regWrite, regRead, extRun, ovfSeen;
	logic [2:0] regAddr;
	logic [7:0] regWrData, regRdData, b;
	logic toggleOut, toggleOutEnable, overflowPulse, timerIrq;
	logic [15:0] val, w;
	wire logic countInputPin, extTriggerPin, extClockPin;
	int failures, compares;
	int n, cyc;
	int divs[4] = '{12, 1, 64, 2};
	up_down_capture_reload_timer dut (
		.core_clk(core_clk),
		.rst(rst),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrite(regWrite),
		.regRead(regRead),
		.regRdData(regRdData),
		.countInputPin(countInputPin),
		.extTriggerPin(extTriggerPin),
		.extClockPin(extClockPin),
		.toggleOut(toggleOut),
		.toggleOutEnable(toggleOutEnable),
		.overflowPulse(overflowPulse),
		.timerIrq(timerIrq)
	);
	pin_model pins (
		.core_clk(core_clk),
		.extRun(extRun),
		.countPin(countInputPin),
		.trigPin(extTriggerPin),
		.extClk(extClockPin)
	);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (overflowPulse === 1'b1) ovfSeen <= 1'b1;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic wrWord(input logic [2:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 3'h1, v[15:8]);
	endtask
	task automatic rdWord(input logic [2:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 3'h1, v[15:8]);
	endtask
	task automatic endTest(input string name);
		$display("test %s done", name);
	endtask
	// Cycles until toggleOut next changes, sampled clear of the edge
	task automatic halfPeriod(output int c);
		logic t;
		#1 t = toggleOut;
		c = 0;
		while (toggleOut === t && c < 200) begin
			@(posedge core_clk);
			#1 c++;
		end
	endtask
	task automatic complete_run;
		$display("compares %0d, failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#400_000;
		failures++;
		complete_run;
	end
	initial begin
		rst = 1'b1;
		{regWrite, regRead, extRun, ovfSeen} = 4'h0;
		regAddr = 3'h0;
		regWrData = 8'h00;
		void'($urandom(32'h4857b20f));
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), b);
			check({8'h00, b}, 16'h0000);
		end
		endTest("reset");
		repeat (4) begin
			val = 16'($urandom);
			wrWord(CNT, val);
			wrWord(RLD, ~val);
			repeat (20) @(posedge core_clk);
			rdWord(CNT, w);
			check(w, val);
			rdWord(RLD, w);
			check(w, ~val);
		end
		endTest("bytes");
		// Tolerance covers synchroniser and prescaler phase
		extRun = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wrWord(CNT, 16'h0000);
			wr(CFG, {3'h0, 2'(i), 3'h0});
			wr(CTL, 8'h04);
			repeat (238) @(posedge core_clk);
			wr(CTL, 8'h00);
			rdWord(CNT, w);
			check({15'h0, w + 16'h2 >= 16'(240 / divs[i]) && w <= 16'(240 / divs[i] + 2)},
				16'h0001);
		end
		extRun = 1'b0;
		endTest("clocks");
		val = {1'b0, 15'($urandom)};
		wr(CFG, 8'h00);
		wrWord(CNT, val);
		wr(CTL, 8'h07);
		pins.setTrig(1'b0);
		pins.setTrig(1'b1);
		rd(CTL, b);
		check({8'h00, b}, 16'h0007);
		wr(CTL, 8'h0f);
		pins.setTrig(1'b0);
		pins.setTrig(1'b1);
		pins.fallCount(3);
		rd(CTL, b);
		check({8'h00, b}, 16'h004f);
		check({15'h0, timerIrq}, 16'h0001);
		rdWord(RLD, w);
		check(w, val);
		rdWord(CNT, w);
		check(w, val + 16'h3);
		endTest("capture");
		wrWord(CNT, 16'h0000);
		wrWord(RLD, 16'h1234);
		wr(CFG, 8'h01);
		wr(CTL, 8'h0f);
		pins.setTrig(1'b0);
		pins.fallCount(1);
		rdWord(CNT, w);
		check(w, 16'hffff);
		rd(CTL, b);
		check({8'h00, b}, 16'h008f);
		rdWord(RLD, w);
		check(w, 16'h1234);
		wr(CTL, 8'h00);
		pins.setTrig(1'b1);
		endTest("capture down");
		wr(CFG, 8'h06);
		#1;
		check({14'h0, toggleOut, toggleOutEnable}, 16'h0003);
		wrWord(RLD, 16'hfffe);
		wrWord(CNT, 16'hffff);
		ovfSeen <= 1'b0;
		wr(CTL, 8'h06);
		pins.fallCount(1);
		rdWord(CNT, w);
		check(w, 16'hfffe);
		rd(CTL, b);
		check({8'h00, b}, 16'h00c6);
		check({14'h0, ovfSeen, toggleOut}, 16'h0002);
		pins.fallCount(2);
		rd(CTL, b);
		check({8'h00, b}, 16'h0086);
		check({15'h0, toggleOut}, 16'h0001);
		wr(CTL, 8'h0e);
		wrWord(CNT, 16'h0100);
		pins.setTrig(1'b0);
		pins.setTrig(1'b1);
		rdWord(CNT, w);
		check(w, 16'hfffe);
		rd(CTL, b);
		check({8'h00, b}, 16'h004e);
		check({15'h0, timerIrq}, 16'h0000);
		endTest("reload up");
		wr(CTL, 8'h06);
		wr(CFG, 8'h01);
		pins.setTrig(1'b0);
		wrWord(RLD, 16'h0005);
		wrWord(CNT, 16'h0005);
		pins.fallCount(1);
		rdWord(CNT, w);
		check(w, 16'hffff);
		rd(CTL, b);
		check({8'h00, b}, 16'h00c6);
		wr(CTL, 8'h02);
		pins.fallCount(2);
		rdWord(CNT, w);
		check(w, 16'hffff);
		endTest("reload down");
		// Square wave on the system clock, up then down; trigger pin is low
		for (int d = 0; d < 2; d++) begin
			n = 4 + int'($urandom % 32);
			wr(CFG, {7'h05, d[0]});
			wrWord(RLD, 16'(65536 - n));
			wrWord(CNT, 16'(65536 - n));
			wr(CTL, 8'h04);
			halfPeriod(cyc);
			halfPeriod(cyc);
			check(16'(cyc), 16'(n));
			wr(CTL, 8'h00);
		end
		endTest("square wave");
		complete_run;
	end
endmodule // up_down_capture_reload_timer_bench
`default_nettype wire
